/* gdc_top.sv */
/*
  Gate drive timing state machine, gate current settings and shunt
  amplifier control, with an AXI4-Lite register slave and one interrupt.
  Command and gate monitor inputs are pins from outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// - Twelve gate current levels, one shared high-side and one shared low-side.
// - Gate current settings are writable at any time, standby or operating.
// - Opposite transistor enabled only after monitor shows conducting one off.
// - Programmed dead time starts only after the handshake has completed.
// - Any command enables strong drive and starts the drive window.
// - Gate not at commanded level at window end flags fault, disables drive.
// - Successful turn-on drops to hold current when the window ends; turn-off drops strong sink once the handshake completes.
// - Window never stretches a pulse; a new command aborts it at once.
// - Each of three amplifiers has its own configuration and calibration.
// - Amplifier gain selectable as 10, 20, 40 or 80.
// - Amplifier output bias is one half or one quarter of reference.
// - Blanking starts on any gate output edge, shared by all amplifiers.
// - A further edge during blanking restarts the interval.
// - Blanking time is zero after reset.
// - Calibration shorts the amplifier inputs and disconnects its load.
// - Calibration is allowed at any time, preferably while switching off.
// - Gate fault turns drivers off, high impedance, fault pin held low.
module gdc_top
  import gdc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] high_side_command_inputs,
  input wire logic [2:0] low_side_command_inputs,
  input wire logic [2:0] hs_gate_monitor,
  input wire logic [2:0] ls_gate_monitor,
  output logic [2:0] hs_gate_on,
  output logic [2:0] ls_gate_on,
  output logic [2:0] hs_gate_strong,
  output logic [2:0] ls_gate_strong,
  output logic gate_hiz,
  output logic [3:0] hs_current_level,
  output logic [3:0] ls_current_level,
  output logic [5:0] csa_gain,
  output logic [2:0] csa_bias_quarter,
  output logic [2:0] csa_cal_short,
  output logic csa_blank,
  output logic fault_pin_n_o,
  output logic fault_pin_n_oe,
  output logic irq
);
  import gdc_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [3:0] clamp_level(input logic [3:0] v);
    return (v > LEVEL_MAX) ? LEVEL_MAX : v;
  endfunction

  function automatic logic [1:0] want_side(input logic hs, input logic ls);
    if (hs && !ls) begin
      return SIDE_HS;
    end else if (ls && !hs) begin
      return SIDE_LS;
    end
    return SIDE_NONE;
  endfunction

  function automatic logic mon_ok(input logic [1:0] side, input logic hs,
                                  input logic ls);
    return (side == SIDE_HS) ? (hs && !ls) :
           (side == SIDE_LS) ? (ls && !hs) : (!hs && !ls);
  endfunction

  function automatic logic [7:0] at_least_one(input logic [7:0] v);
    return (v == 8'h00) ? 8'h01 : v;
  endfunction

  // Pin synchronisers: a change counts once stages two and three agree.
  logic [11:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 12'h000;
      pin_s2_q <= 12'h000;
      pin_s3_q <= 12'h000;
      pin_q <= 12'h000;
    end else begin
      pin_s1_q <= {ls_gate_monitor, hs_gate_monitor,
                   low_side_command_inputs, high_side_command_inputs};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < 12; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end
  logic [2:0] cmd_hs, cmd_ls, mon_hs, mon_ls;
  assign cmd_hs = pin_q[2:0];
  assign cmd_ls = pin_q[5:3];
  assign mon_hs = pin_q[8:6];
  assign mon_ls = pin_q[11:9];

  // Registers.
  logic [31:0] drive_cfg_q, csa_cfg_q;
  logic [2:0] status_q, mask_q;
  logic fault_q;
  logic [2:0] flt_evt_q;
  logic wr_fire, rd_fire;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q, w_have_q;

  // Write channel: address and data taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q[1:0] == 2'h0 && awaddr_q <= CONTROL_OFS) ?
                       RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign s_axi_awready = !aw_have_q && aresetn;
  assign s_axi_wready = !w_have_q && aresetn;

  // Settings may change in any state; the gate machine reads them live.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_cfg_q <= {8'h00, WINDOW_RST, DEAD_RST, LEVEL_RST, LEVEL_RST};
      csa_cfg_q <= {8'h00, BLANK_RST, 4'h0, CSA_RST, CSA_RST, CSA_RST};
      mask_q <= 3'h0;
    end else if (wr_fire) begin
      unique case (awaddr_q)
        DRIVE_CFG_OFS: drive_cfg_q <= merge(drive_cfg_q, wdata_q, wstrb_q);
        CSA_CFG_OFS: csa_cfg_q <= merge(csa_cfg_q, wdata_q, wstrb_q);
        IRQ_MASK_OFS: mask_q <= 3'(merge({29'h0, mask_q}, wdata_q,
                                         wstrb_q));
        default: ;
      endcase
    end
  end

  logic wr_status, wr_clear;
  assign wr_status = wr_fire && awaddr_q == STATUS_OFS && wstrb_q[0];
  assign wr_clear = wr_fire && awaddr_q == CONTROL_OFS && wstrb_q[0] &&
                    wdata_q[CLEAR_FAULT_POS];

  // Sticky fault status, cleared by writing one; a new event wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= 3'h0;
      irq <= 1'b0;
    end else begin
      status_q <= (status_q & ~(wr_status ? wdata_q[ST_FAULT_POS +: 3] :
                   3'h0)) | flt_evt_q;
      irq <= |(status_q & mask_q);
    end
  end

  // Latched shutdown; the clear command self clears and loses to a new fault.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q <= 1'b0;
      gate_hiz <= 1'b0;
      fault_pin_n_oe <= 1'b0;
      fault_pin_n_o <= 1'b0;
    end else begin
      fault_q <= (|flt_evt_q) || (fault_q && !wr_clear);
      gate_hiz <= (|flt_evt_q) || (fault_q && !wr_clear);
      fault_pin_n_oe <= (|flt_evt_q) || (fault_q && !wr_clear);
      fault_pin_n_o <= 1'b0;
    end
  end

  // Read channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        DRIVE_CFG_OFS: s_axi_rdata <= drive_cfg_q;
        CSA_CFG_OFS: s_axi_rdata <= csa_cfg_q;
        STATUS_OFS: s_axi_rdata <= {22'h0, ls_gate_on, hs_gate_on,
                                    fault_q, status_q};
        IRQ_MASK_OFS: s_axi_rdata <= {29'h0, mask_q};
        CONTROL_OFS: s_axi_rdata <= 32'h00000000;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !s_axi_rvalid && aresetn;

  // Shared current levels and per-amplifier controls, held in flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_current_level <= LEVEL_RST;
      ls_current_level <= LEVEL_RST;
      csa_gain <= 6'h00;
      csa_bias_quarter <= 3'h0;
      csa_cal_short <= 3'h0;
    end else begin
      hs_current_level <= clamp_level(drive_cfg_q[HS_LEVEL_POS +: 4]);
      ls_current_level <= clamp_level(drive_cfg_q[LS_LEVEL_POS +: 4]);
      for (int a = 0; a < 3; a++) begin
        // Gain code 0..3 selects 10, 20, 40 or 80.
        csa_gain[a*2 +: 2] <= csa_cfg_q[a*CSA_FIELD_W + CSA_GAIN_POS +: 2];
        csa_bias_quarter[a] <= csa_cfg_q[a*CSA_FIELD_W + CSA_BIAS_POS];
        // Calibration is honoured even mid-switching.
        csa_cal_short[a] <= csa_cfg_q[a*CSA_FIELD_W + CSA_CAL_POS];
      end
    end
  end

  // Per-phase gate timing machine.
  gdc_phase_type st_q [3];
  logic [1:0] dst_q [3];
  logic [7:0] win_q [3];
  logic [7:0] dead_q [3];
  logic [7:0] win_cfg, dead_cfg;
  assign win_cfg = at_least_one(drive_cfg_q[WINDOW_POS +: 8]);
  assign dead_cfg = drive_cfg_q[DEAD_POS +: 8];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < 3; p++) begin
        st_q[p] <= PH_OFF;
        dst_q[p] <= SIDE_NONE;
        win_q[p] <= 8'h00;
        dead_q[p] <= 8'h00;
      end
      hs_gate_on <= 3'h0;
      ls_gate_on <= 3'h0;
      hs_gate_strong <= 3'h0;
      ls_gate_strong <= 3'h0;
      flt_evt_q <= 3'h0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        flt_evt_q[p] <= 1'b0;
        if (fault_q || (|flt_evt_q)) begin
          st_q[p] <= PH_OFF;
          dst_q[p] <= SIDE_NONE;
          hs_gate_on[p] <= 1'b0;
          ls_gate_on[p] <= 1'b0;
          hs_gate_strong[p] <= 1'b0;
          ls_gate_strong[p] <= 1'b0;
        end else if (want_side(cmd_hs[p], cmd_ls[p]) != dst_q[p]) begin
          // New command: drop the conducting gate with strong sink and
          // restart the window, aborting any window in progress.
          st_q[p] <= PH_TOFF;
          dst_q[p] <= want_side(cmd_hs[p], cmd_ls[p]);
          win_q[p] <= win_cfg;
          hs_gate_strong[p] <= hs_gate_on[p] || hs_gate_strong[p];
          ls_gate_strong[p] <= ls_gate_on[p] || ls_gate_strong[p];
          hs_gate_on[p] <= 1'b0;
          ls_gate_on[p] <= 1'b0;
        end else begin
          unique case (st_q[p])
            PH_OFF, PH_HOLD: ;
            PH_TOFF: begin
              win_q[p] <= win_q[p] - 8'h01;
              if (!mon_hs[p] && !mon_ls[p]) begin
                // Handshake done; dead time only follows it.
                hs_gate_strong[p] <= 1'b0;
                ls_gate_strong[p] <= 1'b0;
                if (dst_q[p] == SIDE_NONE) begin
                  st_q[p] <= PH_HOLD;
                end else begin
                  st_q[p] <= PH_DEAD;
                  dead_q[p] <= dead_cfg;
                end
              end else if (win_q[p] == 8'h01) begin
                flt_evt_q[p] <= 1'b1;
              end
            end
            PH_DEAD: begin
              if (dead_q[p] == 8'h00) begin
                st_q[p] <= PH_TON;
                win_q[p] <= win_cfg;
                hs_gate_on[p] <= dst_q[p] == SIDE_HS;
                ls_gate_on[p] <= dst_q[p] == SIDE_LS;
                hs_gate_strong[p] <= dst_q[p] == SIDE_HS;
                ls_gate_strong[p] <= dst_q[p] == SIDE_LS;
              end else begin
                dead_q[p] <= dead_q[p] - 8'h01;
              end
            end
            PH_TON: begin
              win_q[p] <= win_q[p] - 8'h01;
              if (win_q[p] == 8'h01) begin
                if (mon_ok(dst_q[p], mon_hs[p], mon_ls[p])) begin
                  st_q[p] <= PH_HOLD;
                  hs_gate_strong[p] <= 1'b0;
                  ls_gate_strong[p] <= 1'b0;
                end else begin
                  flt_evt_q[p] <= 1'b1;
                end
              end
            end
          endcase
        end
      end
    end
  end

  // Shared amplifier blanking, restarted by every gate output edge.
  logic [5:0] gates_prev_q;
  logic [7:0] blank_q;
  logic gate_edge;
  assign gate_edge = gates_prev_q != {ls_gate_on, hs_gate_on};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gates_prev_q <= 6'h00;
      blank_q <= 8'h00;
      csa_blank <= 1'b0;
    end else begin
      gates_prev_q <= {ls_gate_on, hs_gate_on};
      if (gate_edge) begin
        blank_q <= csa_cfg_q[BLANK_POS +: 8];
        csa_blank <= csa_cfg_q[BLANK_POS +: 8] != 8'h00;
      end else if (blank_q != 8'h00) begin
        blank_q <= blank_q - 8'h01;
        csa_blank <= blank_q != 8'h01;
      end else begin
        csa_blank <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_no_cross_drive: assert property ((hs_gate_on & ls_gate_on) == 3'h0)
    else $error("both gates of a phase enabled");
  a_fault_shutdown: assert property (
    |flt_evt_q |=> gate_hiz && fault_pin_n_oe
    ##1 (hs_gate_on | ls_gate_on) == 3'h0)
    else $error("fault did not shut the drivers down");
  a_on_is_strong: assert property (
    $rose(hs_gate_on[0]) |-> hs_gate_strong[0])
    else $error("turn-on without strong current");
  a_hold_after_ok: assert property (
    st_q[0] == PH_TON && win_q[0] == 8'h01 &&
    mon_ok(dst_q[0], mon_hs[0], mon_ls[0]) && !fault_q && !(|flt_evt_q) &&
    want_side(cmd_hs[0], cmd_ls[0]) == dst_q[0] |=> st_q[0] == PH_HOLD &&
    !hs_gate_strong[0] && !ls_gate_strong[0])
    else $error("no hold current after good switch");
  a_window_fault: assert property (
    st_q[1] == PH_TON && win_q[1] == 8'h01 &&
    !mon_ok(dst_q[1], mon_hs[1], mon_ls[1]) && !fault_q && !(|flt_evt_q) &&
    want_side(cmd_hs[1], cmd_ls[1]) == dst_q[1] |=> flt_evt_q[1])
    else $error("window expiry did not flag a fault");
  a_abort_window: assert property (
    st_q[2] == PH_TON && !fault_q &&
    !(|flt_evt_q) && want_side(cmd_hs[2], cmd_ls[2]) != dst_q[2]
    |=> st_q[2] == PH_TOFF && !hs_gate_on[2] && !ls_gate_on[2])
    else $error("new command did not abort the window");
  a_dead_after_hs: assert property (
    $rose(st_q[0] == PH_DEAD) |-> $past(!mon_hs[0] && !mon_ls[0]))
    else $error("dead time began before the handshake");
  a_blank_restart: assert property (
    gate_edge && csa_cfg_q[BLANK_POS +: 8] > 8'h02 |=> csa_blank [*2])
    else $error("blanking not restarted on edge");
  a_level_clamp: assert property (
    hs_current_level <= LEVEL_MAX && ls_current_level <= LEVEL_MAX)
    else $error("gate current level out of range");
  a_irq_level: assert property (irq == $past(|(status_q & mask_q)))
    else $error("interrupt does not follow masked status");

  c_good_turn_on: cover property (st_q[0] == PH_TON ##1 st_q[0] == PH_HOLD);
  c_gate_fault: cover property (|flt_evt_q);
  c_blank_restart: cover property (csa_blank && gate_edge);
  c_fault_clear: cover property (fault_q ##1 !fault_q);
endmodule // gdc_top

`default_nettype wire

/* gdc_pkg.sv */
/*
  Constants for the gate drive timing and shunt amplifier control block:
  register offsets, field positions, reset values and encodings.
  Assumes a single 250 MHz clock and an AXI4-Lite register master.
*/
package gdc_pkg;
  localparam logic [7:0] DRIVE_CFG_OFS = 8'h00;
  localparam logic [7:0] CSA_CFG_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
  localparam logic [7:0] CONTROL_OFS = 8'h10;

  localparam int HS_LEVEL_POS = 0;
  localparam int LS_LEVEL_POS = 4;
  localparam int DEAD_POS = 8;
  localparam int WINDOW_POS = 16;
  localparam int CSA_FIELD_W = 4;
  localparam int CSA_GAIN_POS = 0;
  localparam int CSA_BIAS_POS = 2;
  localparam int CSA_CAL_POS = 3;
  localparam int BLANK_POS = 16;
  localparam int ST_FAULT_POS = 0;
  localparam int ST_LATCH_POS = 3;
  localparam int ST_GATES_POS = 4;
  localparam int CLEAR_FAULT_POS = 0;

  localparam logic [3:0] LEVEL_MAX = 4'hB;
  localparam logic [3:0] LEVEL_RST = 4'h0;
  localparam logic [7:0] DEAD_RST = 8'h00;
  localparam logic [7:0] WINDOW_RST = 8'h10;
  localparam logic [7:0] BLANK_RST = 8'h00;
  localparam logic [3:0] CSA_RST = 4'h0;

  localparam logic [1:0] SIDE_NONE = 2'h0;
  localparam logic [1:0] SIDE_HS = 2'h1;
  localparam logic [1:0] SIDE_LS = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    PH_OFF = 5'h01,
    PH_TOFF = 5'h02,
    PH_DEAD = 5'h04,
    PH_TON = 5'h08,
    PH_HOLD = 5'h10
  } gdc_phase_type;
endpackage

/* gdc_bridge_model.sv */
/*
  Behavioural model of three external half-bridges as seen by the gate
  monitors. Assumes gate enables from the block and a shared clock.
*/
`timescale 1ns/1ps
`default_nettype none
module gdc_bridge_model (
  input wire logic aclk,
  input wire logic [2:0] hs_gate_on,
  input wire logic [2:0] ls_gate_on,
  input wire logic [2:0] stuck_off,
  output logic [2:0] hs_gate_monitor,
  output logic [2:0] ls_gate_monitor
);
  logic [2:0] hs_p1_q, hs_p2_q, ls_p1_q, ls_p2_q;
  // Gates settle in three cycles, well inside the 16-cycle window.
  // A stuck high-side gate models a shorted gate that never charges.
  always_ff @(posedge aclk) begin
    hs_p1_q <= hs_gate_on;
    hs_p2_q <= hs_p1_q;
    hs_gate_monitor <= hs_p2_q & ~stuck_off;
    ls_p1_q <= ls_gate_on;
    ls_p2_q <= ls_p1_q;
    ls_gate_monitor <= ls_p2_q;
  end
endmodule // gdc_bridge_model
`default_nettype wire

/* tb_gate_drive_timing_and_csa_control.sv */
/*
  Self-checking bench for the gate drive block: register table, gate
  handshake, drive window, blanking and fault. Assumes gdc_pkg compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_gate_drive_timing_and_csa_control;
  import gdc_pkg::*;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d;
    logic [31:0] x; logic [1:0] rs;} gdc_row_type;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [2:0] high_side_command_inputs = 3'h0;
  logic [2:0] low_side_command_inputs = 3'h0;
  logic [2:0] stuck_off = 3'h0;
  logic [2:0] hs_gate_monitor, ls_gate_monitor, hs_gate_on, ls_gate_on;
  logic [2:0] hs_gate_strong, ls_gate_strong, csa_bias_quarter;
  logic [2:0] csa_cal_short;
  logic [3:0] hs_current_level, ls_current_level;
  logic [5:0] csa_gain;
  logic gate_hiz, csa_blank, fault_pin_n_o, fault_pin_n_oe, irq;
  logic fault_pin_n;
  logic [31:0] rd;
  int n_errors = 0;
  int total_checks = 0;
  int n;
  gdc_row_type rows [10];

  // The fault line has an external pull-up.
  assign fault_pin_n = fault_pin_n_oe ? fault_pin_n_o : 1'b1;
  always #2 aclk = ~aclk;

  gdc_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .high_side_command_inputs,
    .low_side_command_inputs, .hs_gate_monitor, .ls_gate_monitor,
    .hs_gate_on, .ls_gate_on, .hs_gate_strong, .ls_gate_strong, .gate_hiz,
    .hs_current_level, .ls_current_level, .csa_gain, .csa_bias_quarter,
    .csa_cal_short, .csa_blank, .fault_pin_n_o, .fault_pin_n_oe, .irq);

  gdc_bridge_model bridge (.aclk, .hs_gate_on, .ls_gate_on, .stuck_off,
    .hs_gate_monitor, .ls_gate_monitor);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Shoot-through watch: never both gates of a phase, never a low side
  // on while its high-side monitor still shows the gate charged.
  always @(negedge aclk) if (aresetn) begin
    chk({31'h0, |(hs_gate_on & ls_gate_on)}, 32'h0);
    chk({31'h0, |(ls_gate_on & hs_gate_monitor)}, 32'h0);
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    wrap_up();
  end

  initial begin
    rows[0] = '{0, DRIVE_CFG_OFS, 32'h0, 32'h0010_0000, RESP_OKAY};
    rows[1] = '{0, CSA_CFG_OFS, 32'h0, 32'h0, RESP_OKAY};
    rows[2] = '{1, DRIVE_CFG_OFS, 32'h0010_025B, 32'h0, RESP_OKAY};
    rows[3] = '{0, DRIVE_CFG_OFS, 32'h0, 32'h0010_025B, RESP_OKAY};
    rows[4] = '{1, DRIVE_CFG_OFS, 32'h0010_02FC, 32'h0, RESP_OKAY};
    rows[5] = '{0, DRIVE_CFG_OFS, 32'h0, 32'h0010_02FC, RESP_OKAY};
    rows[6] = '{1, CSA_CFG_OFS, 32'h0008_0297, 32'h0, RESP_OKAY};
    rows[7] = '{0, CSA_CFG_OFS, 32'h0, 32'h0008_0297, RESP_OKAY};
    rows[8] = '{0, 8'h14, 32'h0, 32'h0, RESP_SLVERR};
    rows[9] = '{1, 8'h14, 32'h0, 32'h0, RESP_SLVERR};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, rs);
      else begin
        axi_rd(rows[i].a, rd, rs);
        chk(rd, rows[i].x);
      end
      chk({30'h0, rs}, {30'h0, rows[i].rs});
    end
    chk({24'h0, hs_current_level, ls_current_level}, 32'hBB);
    chk({26'h0, csa_gain}, 32'h27);
    chk({29'h0, csa_bias_quarter}, 32'h1);
    chk({29'h0, csa_cal_short}, 32'h2);
    // Phase 0 from off to high side.
    high_side_command_inputs <= 3'b001;
    for (n = 0; n < 60 && hs_gate_on[0] !== 1'b1; n++) @(posedge aclk);
    chk({31'h0, hs_gate_strong[0]}, 32'h1);
    repeat (2) @(posedge aclk);
    chk({31'h0, csa_blank}, 32'h1);
    repeat (22) @(posedge aclk);
    chk({30'h0, hs_gate_on[0], hs_gate_strong[0]}, 32'h2);
    // High to low side; blanking time raised to 0x20 while switching.
    high_side_command_inputs <= 3'b000;
    low_side_command_inputs <= 3'b001;
    axi_wr(CSA_CFG_OFS, 32'h0020_0297, rs);
    for (n = 0; n < 60 && hs_gate_monitor[0] !== 1'b0; n++)
      @(posedge aclk);
    for (n = 0; n < 60 && ls_gate_on[0] !== 1'b1; n++) @(posedge aclk);
    chk({31'h0, n >= 3}, 32'h1);
    chk({31'h0, ls_gate_strong[0]}, 32'h1);
    repeat (24) @(posedge aclk);
    chk({30'h0, ls_gate_on[0], ls_gate_strong[0]}, 32'h2);
    repeat (4) @(posedge aclk);
    chk({31'h0, csa_blank}, 32'h1);
    repeat (7) @(posedge aclk);
    chk({31'h0, csa_blank}, 32'h0);
    // A short pulse on a stuck phase ends the window before it can trip.
    low_side_command_inputs <= 3'b000;
    stuck_off <= 3'b110;
    high_side_command_inputs <= 3'b100;
    repeat (12) @(posedge aclk);
    high_side_command_inputs <= 3'b000;
    repeat (40) @(posedge aclk);
    chk({31'h0, gate_hiz}, 32'h0);
    // A stuck gate runs out the window.
    high_side_command_inputs <= 3'b010;
    for (n = 0; n < 80 && gate_hiz !== 1'b1; n++) @(posedge aclk);
    repeat (2) @(posedge aclk);
    chk({29'h0, gate_hiz, fault_pin_n, fault_pin_n_oe}, 32'h5);
    chk({29'h0, hs_gate_on | ls_gate_on}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    axi_rd(STATUS_OFS, rd, rs);
    chk(rd, 32'h0000_000A);
    axi_wr(IRQ_MASK_OFS, 32'h2, rs);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    high_side_command_inputs <= 3'b000;
    axi_wr(STATUS_OFS, 32'h2, rs);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    axi_wr(CONTROL_OFS, 32'h1, rs);
    repeat (2) @(posedge aclk);
    chk({29'h0, gate_hiz, fault_pin_n, fault_pin_n_oe}, 32'h2);
    axi_rd(STATUS_OFS, rd, rs);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule // tb_gate_drive_timing_and_csa_control
`default_nettype wire
